//--- bpe_pkg.sv
package bpe_pkg;

  // Stream geometry and history layout
  localparam int SF_LEN = 64;
  localparam int AW = 10;
  localparam int DW = 16;
  localparam logic [3:0] LOOK_SF = 4'h6;
  localparam logic [3:0] FULL_SF = 4'h7;
  localparam logic [2:0] HIST_SF = 3'h4;
  localparam logic [5:0] DIV_STEPS = 6'h37;

  // Pitch lag limits and tracker tolerance
  localparam logic [8:0] T_MIN = 9'h014;
  localparam logic [8:0] T_MAX = 9'h0E7;
  localparam logic [9:0] TRK_TOL = 10'h004;

  // Operating point limits
  localparam logic [9:0] RATE_MAX = 10'h140;
  localparam logic [9:0] RATE_GA = 10'h0A4;
  localparam logic [9:0] RATE_GB = 10'h0F4;
  localparam logic [7:0] NOISE_MAX = 8'h14;

  // Q15 coefficients
  localparam logic [15:0] EMPH_Q15 = 16'h7333;
  localparam logic [15:0] EBAR_OLD_Q15 = 16'h7EB8;
  localparam logic [15:0] EBAR_NEW_Q15 = 16'h0148;
  localparam logic [15:0] STAB_CUR_Q15 = 16'h6666;
  localparam logic [15:0] STAB_OLD_Q15 = 16'h199A;
  localparam logic [15:0] K_SQRT_Q15 = 16'h1333;
  localparam logic [16:0] ONE_Q15 = 17'h08000;
  localparam logic [16:0] ALPHA_MAX = 17'h04000;
  localparam logic [15:0] LP_K_Q15 = 16'h2000;
  localparam logic [16:0] GAIN_G0 = 17'h04000;
  localparam logic [16:0] GAIN_G1 = 17'h06000;
  localparam logic [16:0] GAIN_G2 = 17'h08000;
  localparam logic [16:0] GAIN_G3 = 17'h0A000;

  // Log domain scaling (Q8)
  localparam logic [15:0] DB_PER_L2 = 16'h0303;
  localparam logic [15:0] L2_PER_DB = 16'h0055;
  localparam logic [7:0] POW_EMAX = 8'h26;

  // Reset values of persistent state
  localparam logic [16:0] EBAR_INIT = 17'h00000;
  localparam logic [15:0] THBAR_INIT = 16'h0000;
  localparam logic [8:0] TRK_INIT = 9'h000;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ACC = 7'h02,
    ST_DIV1 = 7'h04,
    ST_DIV2 = 7'h08,
    ST_ERR = 7'h10,
    ST_UPD = 7'h20,
    ST_OUT = 7'h40
  } bpe_state_e;

  // Approximate log2 in Q8: leading one plus eight fraction bits
  function automatic logic [13:0] lg2_q8(input logic [63:0] x);
    logic [5:0] p;
    logic [63:0] y;
    p = 6'h00;
    for (int i = 0; i < 64; i++) begin
      if (x[i]) begin
        p = 6'(i);
      end
    end
    y = x << (6'h3F - p);
    lg2_q8 = {p, y[62:55]};
  endfunction

  // Approximate 2^x for unsigned Q8 x
  function automatic logic [47:0] pow2_q8(input logic [15:0] l);
    logic [7:0] e;
    logic [47:0] m;
    e = (l[15:8] > POW_EMAX) ? POW_EMAX : l[15:8];
    m = {39'h0, 1'b1, l[7:0]};
    pow2_q8 = (m << e) >> 8;
  endfunction

  // Square root of an unsigned Q15 value, result Q15
  function automatic logic [15:0] sqrt_q15(input logic [15:0] x);
    logic [31:0] v;
    logic [31:0] t;
    logic [15:0] r;
    v = {1'b0, x, 15'h0000};
    r = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      t = {16'h0000, r | (16'h0001 << i)};
      if (t * t <= v) begin
        r = r | (16'h0001 << i);
      end
    end
    sqrt_q15 = r;
  endfunction

  function automatic logic [9:0] adiff10(input logic [9:0] a, input logic [9:0] b);
    adiff10 = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
    if (x > 32'sh00007FFF) begin
      sat16 = 16'sh7FFF;
    end else if (x < 32'shFFFF8000) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = x[15:0];
    end
  endfunction

endpackage

//--- bpe_hist_mem.sv
`timescale 1ns/1ps
`default_nettype none
module bpe_hist_mem import bpe_pkg::*; (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Sync reset, read port only
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] wr_addr, // Write address
  input wire logic [DW-1:0] wr_data, // Write sample
  input wire logic [AW-1:0] rd_addr, // Read address
  output logic [DW-1:0] rd_data // Registered read sample
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rd_nxt;

  // Read mux
  always_comb begin
    rd_nxt = mem[rd_addr];
  end

  // Array write and read register
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (reset) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

//--- bpe_div.sv
`timescale 1ns/1ps
`default_nettype none
module bpe_div import bpe_pkg::*; (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic start, // Start pulse
  input wire logic [39:0] num, // Dividend, held during busy
  input wire logic [39:0] den, // Divisor, held during busy
  output logic done, // One-cycle result pulse
  output logic [17:0] quo // Q15 quotient, saturated
);
  logic [54:0] nq_r, nq_nxt;
  logic [40:0] rem_r, rem_nxt, rsh;
  logic [5:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt;
  logic [17:0] quo_r, quo_nxt;

  // Shift-subtract step, one quotient bit per cycle
  always_comb begin
    nq_nxt = nq_r;
    rem_nxt = rem_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    quo_nxt = quo_r;
    rsh = {rem_r[39:0], nq_r[54]};
    if (start) begin
      nq_nxt = {num, 15'h0000};
      rem_nxt = '0;
      cnt_nxt = DIV_STEPS;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      nq_nxt = {nq_r[53:0], 1'b0};
      if (rsh >= {1'b0, den}) begin
        rem_nxt = rsh - {1'b0, den};
        nq_nxt[0] = 1'b1;
      end else begin
        rem_nxt = rsh;
      end
      cnt_nxt = cnt_r - 6'h01;
      if (cnt_r == 6'h01) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        quo_nxt = (|nq_nxt[54:18]) ? 18'h3FFFF : nq_nxt[17:0];
      end
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nq_r <= '0;
      rem_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      quo_r <= '0;
    end else begin
      nq_r <= nq_nxt;
      rem_r <= rem_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      quo_r <= quo_nxt;
    end
  end

  assign done = done_r;
  assign quo = quo_r;
endmodule
`default_nettype wire

//--- bpe_enhancer.sv
// Contract
// RULE1: Bypass above 32 kbit/s, noisy narrowband, non-LP
// RULE2: Only lower band enhanced, upper passes
// RULE3: Low-passed difference added to decoded signal
// RULE4: Enhanced is alpha blend of decoded, prediction
// RULE5: Prediction averages samples one lag back, ahead
// RULE6: Upstream supplies closed-loop lag per subframe
// RULE7: Onset uses next subframe lag forward
// RULE8: Tracker smooths lag, removes doubling
// RULE9: Accumulate correlation and prediction energy
// RULE10: Alpha from correlation, energy, mean error; clamped
// RULE11: Prediction error uses ratio, k2 constant
// RULE12: Error emphasized with 0.9 feedback
// RULE13: Error energy taken in decibels
// RULE14: Mean error energy 0.99/0.01 smoothing, zero start
// RULE15: Smoothed stability 0.8 current, 0.2 old
// RULE16: Alpha scaled by stability term
// RULE17: Gain code scales alpha at two rates
// RULE18: Subframe-length sums, state persists
`timescale 1ns/1ps
`default_nettype none
module bpe_enhancer import bpe_pkg::*; (
  input wire logic sys_clk, // Clock, 100 MHz
  input wire logic reset, // Sync reset, active high
  input wire logic in_valid, // Decoded sample offered
  input wire logic signed [15:0] in_sample, // Decoded sample
  output logic in_ready, // Sample accepted when high
  input wire logic lag_valid, // Subframe parameters strobe
  input wire logic [8:0] lag_in, // Closed-loop pitch lag
  input wire logic onset_in, // Voiced onset subframe
  input wire logic [15:0] theta_in, // Stability factor Q15
  input wire logic frame_first_in, // First subframe of frame
  input wire logic [1:0] gain_code_in, // Two-bit gain adjustment
  input wire logic lp_mode, // LP-based coding mode
  input wire logic narrowband, // Narrowband decoding
  input wire logic [7:0] noise_lvl, // Background noise level
  input wire logic [9:0] rate_kbps10, // Bit rate in 0.1 kbit/s
  input wire logic k1_half, // Alpha constant 0.5, else 1
  input wire logic k2_ratio, // Error constant is ratio, else 1
  output logic out_valid, // Output sample pulse
  output logic signed [15:0] out_sample, // Enhanced output
  output logic signed [15:0] out_diff, // Enhancement signal
  output logic [16:0] out_alpha // Weighting factor Q15
);
  bpe_state_e st_r, st_nxt;
  logic [5:0] n_r, n_nxt, wr_n_r, wr_n_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] proc_r, proc_nxt, wr_sf_r, wr_sf_nxt, pend_r, pend_nxt;
  logic [2:0] hist_r, hist_nxt, qi, qf;
  logic signed [15:0] past_r, past_nxt, fut_r, fut_nxt, cur, lp_r, lp_nxt;
  logic signed [39:0] cp_r, cp_nxt;
  logic [39:0] ep_r, ep_nxt, cp_abs, den_a, div_num, div_den;
  logic signed [18:0] ratio_r, ratio_nxt;
  logic [16:0] alpha_r, alpha_nxt, a_stab, a_gain, f_u, gain;
  logic signed [31:0] epp_r, epp_nxt, epp_new;
  logic [63:0] esum_r, esum_nxt;
  logic [16:0] ebar_r, ebar_nxt, edb;
  logic [15:0] thbar_r, thbar_nxt, thb_u, thb, theta;
  logic byp_r, byp_nxt, byp_now, div_go_r, div_go_nxt, div_done, last, wr_go;
  logic in_ready_r, in_ready_nxt, ov_r, ov_nxt;
  logic signed [15:0] os_r, os_nxt, od_r, od_nxt;
  logic [8:0] trk_r, trk_nxt, lag_c, lag_h, lag_p, lag_f;
  logic [8:0] lag_q_r [8], lag_q_nxt [8];
  logic [15:0] th_q_r [8], th_q_nxt [8];
  logic [1:0] gn_q_r [8], gn_q_nxt [8];
  logic [7:0] on_q_r, on_q_nxt, ff_q_r, ff_q_nxt;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic [17:0] div_q;
  logic [40:0] den_sum;
  logic [47:0] pw;
  logic signed [16:0] sp;
  logic signed [19:0] f_s;
  logic signed [23:0] ep_v;
  logic signed [20:0] r_v;

  bpe_hist_mem u_mem (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_en(wr_go),
    .wr_addr({wr_sf_r, wr_n_r}),
    .wr_data(in_sample),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  bpe_div u_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(div_go_r),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_q)
  );

  // Write side, lag tracking and parameter queue
  always_comb begin
    wr_go = in_valid && in_ready_r;
    wr_n_nxt = wr_go ? wr_n_r + 6'h01 : wr_n_r;
    wr_sf_nxt = (wr_go && wr_n_r == 6'h3F) ? wr_sf_r + 4'h1 : wr_sf_r;
    lag_q_nxt = lag_q_r;
    th_q_nxt = th_q_r;
    gn_q_nxt = gn_q_r;
    on_q_nxt = on_q_r;
    ff_q_nxt = ff_q_r;
    trk_nxt = trk_r;
    lag_c = (lag_in < T_MIN) ? T_MIN : ((lag_in > T_MAX) ? T_MAX : lag_in);
    lag_h = lag_c;
    // RULE8: halve doubled lag
    if (trk_r != TRK_INIT && adiff10({1'b0, lag_c}, {trk_r, 1'b0}) <= TRK_TOL
        && (lag_c >> 1) >= T_MIN) begin
      lag_h = lag_c >> 1;
    end
    if (lag_valid) begin
      // RULE8: smooth small lag steps
      if (trk_r != TRK_INIT && adiff10({1'b0, lag_h}, {1'b0, trk_r}) <= TRK_TOL) begin
        trk_nxt = 9'((10'(lag_h) + 10'(trk_r)) >> 1);
      end else begin
        trk_nxt = lag_h;
      end
      // RULE6: lag stored per subframe
      lag_q_nxt[wr_sf_r[2:0]] = trk_nxt;
      th_q_nxt[wr_sf_r[2:0]] = theta_in;
      gn_q_nxt[wr_sf_r[2:0]] = gain_code_in;
      on_q_nxt[wr_sf_r[2:0]] = onset_in;
      ff_q_nxt[wr_sf_r[2:0]] = frame_first_in;
    end
  end

  // Per-sample datapath for the current subframe
  always_comb begin
    qi = proc_r[2:0];
    qf = proc_r[2:0] + 3'h1;
    lag_p = lag_q_r[qi];
    // RULE7: onset forward lag from next subframe
    lag_f = on_q_r[qi] ? lag_q_r[qf] : lag_p;
    theta = th_q_r[qi];
    cur = rd_data;
    case (ph_r)
      2'h0: rd_addr = 10'({proc_r, n_r} - {1'b0, lag_p});
      2'h1: rd_addr = 10'({proc_r, n_r} + {1'b0, lag_f});
      default: rd_addr = {proc_r, n_r};
    endcase
    // RULE5: two-sided prediction
    sp = 17'((18'(past_r) + 18'(fut_r)) >>> 1);
    // RULE11: prediction error
    ep_v = 24'(((k2_ratio ? 40'(ratio_r) * 40'(cur) : 40'(cur) <<< 15)
      - 40'(ratio_r) * 40'(sp)) >>> 15);
    // RULE12: low-frequency emphasis
    epp_new = 32'(ep_v) + 32'((48'($signed({1'b0, EMPH_Q15})) * 48'(epp_r)) >>> 15);
    // RULE4: enhanced minus decoded is alpha times (sp - s)
    r_v = 21'((40'($signed({1'b0, alpha_r})) * (40'(sp) - 40'(cur))) >>> 15);
    cp_abs = cp_r[39] ? 40'(-cp_r) : 40'(cp_r);
    pw = pow2_q8(16'((33'(ebar_r) * 33'(L2_PER_DB)) >> 8));
    den_sum = {1'b0, ep_r} + {1'b0, pw[39:0]};
    den_a = den_sum[40] ? 40'hFF_FFFF_FFFF : den_sum[39:0];
    div_num = (st_r == ST_DIV2 && k1_half) ? cp_abs >> 1 : cp_abs;
    div_den = (st_r == ST_DIV2) ? den_a : ep_r;
    // RULE13: energy in dB
    edb = 17'((30'(lg2_q8(esum_r)) * 30'(DB_PER_L2)) >> 8);
    // RULE15: smoothed stability
    thb_u = 16'((33'(STAB_CUR_Q15) * 33'(theta) + 33'(STAB_OLD_Q15) * 33'(thbar_r)) >> 15);
    thb = ff_q_r[qi] ? thb_u : thbar_r;
    // RULE16: stability scaling term
    f_s = $signed({3'h0, ONE_Q15})
      + $signed({4'h0, 16'((32'(K_SQRT_Q15) * 32'(sqrt_q15(theta))) >> 15)})
      - $signed({2'h0, adiff10({1'b0, thb[15:7]}, {1'b0, theta[15:7]}), 8'h00});
    f_u = f_s[19] ? 17'h00000 : f_s[16:0];
    a_stab = 17'((34'(alpha_r) * 34'(f_u)) >> 15);
    case (gn_q_r[qi])
      2'h0: gain = GAIN_G0;
      2'h1: gain = GAIN_G1;
      2'h2: gain = GAIN_G2;
      default: gain = GAIN_G3;
    endcase
    // RULE17: gain code at the two rates
    a_gain = (rate_kbps10 == RATE_GA || rate_kbps10 == RATE_GB)
      ? 17'((34'(a_stab) * 34'(gain)) >> 15) : a_stab;
    // RULE1: bypass decision
    byp_now = !lp_mode || rate_kbps10 > RATE_MAX || (narrowband && noise_lvl > NOISE_MAX);
    last = ph_r == 2'h3 && n_r == 6'h3F;
  end

  // Subframe sequencer
  always_comb begin
    st_nxt = st_r;
    n_nxt = n_r;
    ph_nxt = ph_r;
    proc_nxt = proc_r;
    hist_nxt = hist_r;
    past_nxt = past_r;
    fut_nxt = fut_r;
    cp_nxt = cp_r;
    ep_nxt = ep_r;
    ratio_nxt = ratio_r;
    alpha_nxt = alpha_r;
    epp_nxt = epp_r;
    esum_nxt = esum_r;
    ebar_nxt = ebar_r;
    thbar_nxt = thbar_r;
    byp_nxt = byp_r;
    lp_nxt = lp_r;
    div_go_nxt = 1'b0;
    ov_nxt = 1'b0;
    os_nxt = os_r;
    od_nxt = od_r;
    if (st_r == ST_ACC || st_r == ST_ERR || st_r == ST_OUT) begin
      ph_nxt = ph_r + 2'h1;
      n_nxt = (ph_r == 2'h3) ? n_r + 6'h01 : n_r;
      if (ph_r == 2'h1) begin
        past_nxt = (hist_r == HIST_SF) ? $signed(rd_data) : 16'sh0000;
      end
      if (ph_r == 2'h2) begin
        fut_nxt = rd_data;
      end
    end
    case (st_r)
      ST_IDLE: begin
        if (pend_r >= LOOK_SF) begin
          n_nxt = 6'h00;
          ph_nxt = 2'h0;
          cp_nxt = '0;
          ep_nxt = '0;
          esum_nxt = '0;
          byp_nxt = byp_now;
          alpha_nxt = '0;
          st_nxt = byp_now ? ST_OUT : ST_ACC;
        end
      end
      ST_ACC: begin
        if (ph_r == 2'h3) begin
          // RULE9: correlation and energy sums
          cp_nxt = cp_r + 40'(cur * sp);
          ep_nxt = ep_r + 40'($unsigned(40'(sp) * 40'(sp)));
        end
        if (last) begin
          st_nxt = ST_DIV1;
          div_go_nxt = 1'b1;
        end
      end
      ST_DIV1: begin
        if (div_done) begin
          ratio_nxt = cp_r[39] ? -$signed({1'b0, div_q}) : $signed({1'b0, div_q});
          st_nxt = ST_DIV2;
          div_go_nxt = 1'b1;
        end
      end
      ST_DIV2: begin
        if (div_done) begin
          // RULE10: clamp alpha to 0..0.5
          alpha_nxt = (cp_r[39] || cp_r == '0) ? 17'h00000
            : ((div_q > {1'b0, ALPHA_MAX}) ? ALPHA_MAX : div_q[16:0]);
          st_nxt = ST_ERR;
        end
      end
      ST_ERR: begin
        if (ph_r == 2'h3) begin
          epp_nxt = epp_new;
          esum_nxt = esum_r + 64'($unsigned(64'(epp_new) * 64'(epp_new)));
        end
        if (last) begin
          st_nxt = ST_UPD;
        end
      end
      ST_UPD: begin
        // RULE14: mean error energy update
        ebar_nxt = 17'((34'(EBAR_OLD_Q15) * 34'(ebar_r) + 34'(EBAR_NEW_Q15) * 34'(edb)) >> 15);
        thbar_nxt = thb;
        alpha_nxt = a_gain;
        n_nxt = 6'h00;
        ph_nxt = 2'h0;
        st_nxt = ST_OUT;
      end
      ST_OUT: begin
        if (ph_r == 2'h3) begin
          // RULE2: low band of difference only
          lp_nxt = sat16(32'(lp_r)
            + 32'(((48'(r_v) - 48'(lp_r)) * 48'($signed({1'b0, LP_K_Q15}))) >>> 15));
          // RULE3: decoded plus low-passed difference
          os_nxt = sat16(32'(cur) + 32'(lp_nxt));
          od_nxt = sat16(32'(r_v));
          ov_nxt = 1'b1;
        end
        if (last) begin
          // RULE18: advance one subframe
          proc_nxt = proc_r + 4'h1;
          hist_nxt = (hist_r == HIST_SF) ? hist_r : hist_r + 3'h1;
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    pend_nxt = wr_sf_nxt - proc_nxt;
    in_ready_nxt = pend_nxt < FULL_SF;
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= ST_IDLE;
      {n_r, ph_r, proc_r, hist_r, wr_n_r, wr_sf_r, pend_r} <= '0;
      {past_r, fut_r, cp_r, ep_r, ratio_r, alpha_r, epp_r, esum_r} <= '0;
      ebar_r <= EBAR_INIT;
      thbar_r <= THBAR_INIT;
      trk_r <= TRK_INIT;
      {byp_r, div_go_r, ov_r, os_r, od_r, lp_r, on_q_r, ff_q_r} <= '0;
      in_ready_r <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        lag_q_r[i] <= TRK_INIT;
        th_q_r[i] <= THBAR_INIT;
        gn_q_r[i] <= 2'h0;
      end
    end else begin
      st_r <= st_nxt;
      {n_r, ph_r, proc_r, hist_r} <= {n_nxt, ph_nxt, proc_nxt, hist_nxt};
      {wr_n_r, wr_sf_r, pend_r} <= {wr_n_nxt, wr_sf_nxt, pend_nxt};
      {past_r, fut_r, cp_r, ep_r} <= {past_nxt, fut_nxt, cp_nxt, ep_nxt};
      {ratio_r, alpha_r, epp_r, esum_r} <= {ratio_nxt, alpha_nxt, epp_nxt, esum_nxt};
      {ebar_r, thbar_r, trk_r, byp_r} <= {ebar_nxt, thbar_nxt, trk_nxt, byp_nxt};
      {div_go_r, ov_r, os_r, od_r, lp_r} <= {div_go_nxt, ov_nxt, os_nxt, od_nxt, lp_nxt};
      {on_q_r, ff_q_r, in_ready_r} <= {on_q_nxt, ff_q_nxt, in_ready_nxt};
      lag_q_r <= lag_q_nxt;
      th_q_r <= th_q_nxt;
      gn_q_r <= gn_q_nxt;
    end
  end

  assign in_ready = in_ready_r;
  assign out_valid = ov_r;
  assign out_sample = os_r;
  assign out_diff = od_r;
  assign out_alpha = alpha_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_bypass_diff: assert property (out_valid && byp_r |-> out_diff == 16'sh0000) // RULE1
    else $error("bypassed subframe produced a difference");
  a_acc_length: assert property ($rose(st_r == ST_ACC) |-> ##256 st_r == ST_DIV1) // RULE9
    else $error("accumulation did not span one subframe");
  a_alpha_clamp: assert property (st_r == ST_DIV2 && div_done |=> alpha_r <= ALPHA_MAX) // RULE10
    else $error("alpha above half before scaling");
  a_ebar_when: assert property ($changed(ebar_r) |-> $past(st_r) == ST_UPD) // RULE14
    else $error("mean error energy changed outside update");
  a_thbar_when: assert property ($changed(thbar_r) |-> $past(st_r == ST_UPD && ff_q_r[qi])) // RULE15
    else $error("stability smoothed outside frame start");
  a_out_pace: assert property (out_valid |=> !out_valid [*3]) // RULE3
    else $error("output samples closer than four cycles");
  a_lag_range: assert property (lag_valid |=> trk_r >= T_MIN && trk_r <= T_MAX) // RULE8
    else $error("tracked lag outside limits");
  a_ready_stop: assert property (pend_r >= FULL_SF |-> !in_ready) // RULE18
    else $error("input accepted with history full");
  a_upd_to_out: assert property (st_r == ST_UPD |=> st_r == ST_OUT ##256 st_r == ST_IDLE) // RULE16
    else $error("scaled alpha not followed by one output subframe");
endmodule
`default_nettype wire

//--- bpe_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module bpe_src_model import bpe_pkg::*; (
  input wire logic sys_clk, // Clock
  input wire logic in_ready, // Enhancer accepts sample
  output logic in_valid, // Sample offered
  output logic signed [15:0] in_sample, // Decoded sample
  output logic lag_valid, // Subframe parameter strobe
  output logic [8:0] lag_in, // Closed-loop pitch lag
  output logic onset_in, // Voiced onset flag
  output logic [15:0] theta_in, // Stability factor
  output logic frame_first_in, // First subframe of frame
  output logic [1:0] gain_code_in // Gain adjustment code
);
  // Idle levels before the first subframe
  initial begin
    in_valid = 1'b0;
    in_sample = 16'sh0000;
    lag_valid = 1'b0;
    lag_in = 9'h014;
    onset_in = 1'b0;
    theta_in = 16'h0000;
    frame_first_in = 1'b0;
    gain_code_in = 2'h0;
  end

  // Feed n subframes of a signal periodic in the lag, holding refused samples
  task automatic send(input int n, input logic [8:0] t, input logic [15:0] th,
                      input logic [1:0] g);
    logic signed [15:0] pat [0:255];
    int k;
    logic sent;
    k = 0;
    sent = 1'b0;
    for (int i = 0; i < 256; i++) begin
      pat[i] = 16'($urandom_range(16000)) - 16'sh1F40;
    end
    while (k < n * SF_LEN) begin
      @(negedge sys_clk);
      in_valid = 1'b1;
      in_sample = pat[k % t];
      lag_valid = !sent;
      lag_in = t;
      // onset flag, next lags always follow
      onset_in = 1'($urandom_range(1));
      theta_in = th;
      // Frames of two subframes
      frame_first_in = 1'((k / SF_LEN) % 2 == 0);
      gain_code_in = g;
      sent = 1'b1;
      @(posedge sys_clk);
      if (in_ready) begin
        k++;
        sent = (k % SF_LEN) != 0;
      end
    end
    @(negedge sys_clk);
    in_valid = 1'b0;
    lag_valid = 1'b0;
    in_sample = ~in_sample;
  endtask
endmodule
`default_nettype wire

//--- bpe_enhancer_test.sv
`timescale 1ns/1ps
`default_nettype none
module bpe_enhancer_test;
  import bpe_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic lp_mode = 1'b1;
  logic narrowband = 1'b0;
  logic [7:0] noise_lvl = 8'h00;
  logic [9:0] rate_kbps10 = 10'h0A4;
  logic k1_half = 1'b0;
  logic k2_ratio = 1'b0;
  logic in_valid, in_ready, lag_valid, onset_in, frame_first_in, out_valid;
  logic signed [15:0] in_sample, out_sample, out_diff;
  logic [8:0] lag_in;
  logic [15:0] theta_in;
  logic [1:0] gain_code_in;
  logic [16:0] out_alpha;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int oc = 0;
  int lastc = 0;
  logic chk = 1'b0;
  logic byp = 1'b0;
  logic [15:0] th_cur = 16'h0000;
  logic [1:0] g_cur = 2'h0;
  logic signed [15:0] in_q [$];

  bpe_enhancer u_dut (.sys_clk(sys_clk), .reset(reset), .in_valid(in_valid),
    .in_sample(in_sample), .in_ready(in_ready), .lag_valid(lag_valid), .lag_in(lag_in),
    .onset_in(onset_in), .theta_in(theta_in), .frame_first_in(frame_first_in),
    .gain_code_in(gain_code_in), .lp_mode(lp_mode), .narrowband(narrowband),
    .noise_lvl(noise_lvl), .rate_kbps10(rate_kbps10), .k1_half(k1_half),
    .k2_ratio(k2_ratio), .out_valid(out_valid), .out_sample(out_sample),
    .out_diff(out_diff), .out_alpha(out_alpha));

  bpe_src_model u_src (.sys_clk(sys_clk), .in_ready(in_ready), .in_valid(in_valid),
    .in_sample(in_sample), .lag_valid(lag_valid), .lag_in(lag_in), .onset_in(onset_in),
    .theta_in(theta_in), .frame_first_in(frame_first_in), .gain_code_in(gain_code_in));

  // Clock
  always #5 sys_clk = ~sys_clk;

  // Expected weighting factor of processed subframe j, Q15
  function automatic logic [16:0] exp_alpha(input int j);
    real d;
    real f;
    real gg;
    d = th_cur / 32768.0;
    // Smoothed stability moves only on even subframes, the frame starts
    f = 1.0 + 0.15 * $sqrt(d) - 2.0 * d * (0.2 ** (j / 2 + 1));
    gg = (rate_kbps10 == 10'h0A4 || rate_kbps10 == 10'h0F4) ? 0.5 + 0.25 * g_cur : 1.0;
    return 17'($rtoi(16384.0 * f * gg));
  endfunction

  task automatic cmp_eq(input logic [16:0] got, input logic [16:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Fixed-point rounding allowed within a small window
  task automatic cmp_near(input logic [16:0] got, input logic [16:0] exp, input string m);
    tests_run++;
    if ($isunknown(got) || got > exp + 17'h00100 || got + 17'h00100 < exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h near %h", $time, m, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cycle count, hang guard and record of accepted samples
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 100000) begin
      err_total++;
      stop_test();
    end
    if (chk && in_valid && in_ready) in_q.push_back(in_sample);
  end

  // Output checks where values are settled
  always @(negedge sys_clk) begin
    if (chk && out_valid === 1'b1) begin
      if (oc % SF_LEN != 0) cmp_eq(17'(cyc - lastc), 17'h00004, "spacing");
      if (byp) begin
        cmp_eq(17'(out_diff), 17'h00000, "diff");
        cmp_eq(17'(out_sample), 17'(in_q[oc]), "sample");
      end else begin
        cmp_near(out_alpha, exp_alpha(oc / SF_LEN), "alpha");
        if (oc >= 4 * SF_LEN) cmp_eq(17'(out_diff), 17'h00000, "diff");
      end
      lastc = cyc;
      oc++;
    end
  end

  // Reset, configure, stream n subframes plus lookahead, collect n subframes of outputs
  task automatic run(input string nm, input logic b, input logic [9:0] rt, input logic lp,
                     input logic nb, input logic [7:0] nz, input logic [15:0] th,
                     input logic [1:0] g, input int n);
    int i;
    @(negedge sys_clk);
    reset = 1'b1;
    lp_mode = lp;
    narrowband = nb;
    noise_lvl = nz;
    rate_kbps10 = rt;
    k1_half = 1'($urandom_range(1));
    k2_ratio = 1'($urandom_range(1));
    byp = b;
    th_cur = th;
    g_cur = g;
    oc = 0;
    in_q.delete();
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    cmp_eq({15'h0000, out_valid, in_ready}, 17'h00001, "reset flags");
    cmp_eq(out_alpha, 17'h00000, "reset alpha");
    chk = 1'b1;
    u_src.send(n + 6, 9'($urandom_range(231, 20)), th, g);
    for (i = 0; i < 20000 && oc < n * SF_LEN; i++) @(negedge sys_clk);
    cmp_eq(17'(oc < n * SF_LEN ? oc : n * SF_LEN), 17'(n * SF_LEN), "count");
    chk = 1'b0;
    $display("test %s done", nm);
  endtask

  initial begin
    void'($urandom(56));
    run("rate", 1'b1, 10'h141, 1'b1, 1'b0, 8'h00, 16'h0000, 2'h0, 2);
    run("nonlp", 1'b1, 10'h0A4, 1'b0, 1'b0, 8'h00, 16'h0000, 2'h0, 2);
    run("noisy", 1'b1, 10'h0A4, 1'b1, 1'b1, 8'h15, 16'h0000, 2'h0, 2);
    run("edge", 1'b0, RATE_MAX, 1'b1, 1'b1, NOISE_MAX, 16'h0000, 2'h3, 2);
    for (int i = 0; i < 5; i++) begin
      run("gain", 1'b0, (i < 4) ? 10'h0A4 : 10'h0F4, 1'b1, 1'b0, 8'h00, 16'h0000, 2'(i), 2);
    end
    run("stab", 1'b0, 10'h0C8, 1'b1, 1'b0, 8'h00, 16'h8000, 2'h0, 6);
    stop_test();
  end
endmodule
`default_nettype wire
